// [tmr_evt_if.sv]
// Interface: counter events shared between counter core and output units
`timescale 1ns/100ps
interface tmr_evt_if;
	logic            tick;
	logic [1:0]      kind;
	logic            count_up;
	logic            at_bottom;
	logic            at_top;
	logic [7:0]      count;
	logic [7:0]      top;
	logic            wave_sel_bit2;

	modport core (output tick, kind, count_up, at_bottom, at_top, count, top, wave_sel_bit2);
	modport unit (input tick, kind, count_up, at_bottom, at_top, count, top, wave_sel_bit2);
endinterface

// [tmr_pkg.sv]
// Package: register map, field layout and mode codes of the 8-bit timer
package tmr_pkg;

	// ==========================================================
	// Register byte addresses (AHB-Lite, one word each, except ADDR_CTRL_A and ADDR_CTRL_B, which share the word at 0x24)
	localparam logic [7:0] ADDR_CTRL_A = 8'h24;
	localparam logic [7:0] ADDR_CTRL_B = 8'h25;
	localparam logic [7:0] ADDR_COUNT  = 8'h28;
	localparam logic [7:0] ADDR_MATCHA = 8'h2C;
	localparam logic [7:0] ADDR_MATCHB = 8'h30;
	localparam logic [7:0] ADDR_FLAGS  = 8'h34;
	localparam logic [7:0] ADDR_PINS   = 8'h38;

	// ==========================================================
	// Field positions
	localparam int CA_OMA_HI = 7;
	localparam int CA_OMA_LO = 6;
	localparam int CA_OMB_HI = 5;
	localparam int CA_OMB_LO = 4;
	localparam int CA_WSL_HI = 1;
	localparam int CA_WSL_LO = 0;
	localparam int CB_WS2    = 3;
	localparam int FL_WRAP   = 0;
	localparam int FL_MA     = 1;
	localparam int FL_MB     = 2;
	localparam int PN_DIRA   = 0;
	localparam int PN_DIRB   = 1;
	localparam int PN_DATA   = 2;
	localparam int PN_DATB   = 3;

	// ==========================================================
	// Reset values and constants
	localparam logic [7:0] CTRL_A_RST = 8'h00;
	localparam logic [7:0] CTRL_A_MSK = 8'hF3;
	localparam logic [7:0] VAL_MAX    = 8'hFF;
	localparam logic [7:0] VAL_BOTTOM = 8'h00;

	// Output mode codes
	localparam logic [1:0] OM_OFF = 2'h0;
	localparam logic [1:0] OM_TGL = 2'h1;
	localparam logic [1:0] OM_CLR = 2'h2;
	localparam logic [1:0] OM_SET = 2'h3;

	typedef enum logic [2:0]
	{
		WM_NORMAL = 3'b000,
		WM_PC_FF  = 3'b001,
		WM_CTC    = 3'b010,
		WM_FP_FF  = 3'b011,
		WM_RSV4   = 3'b100,
		WM_PC_A   = 3'b101,
		WM_RSV6   = 3'b110,
		WM_FP_A   = 3'b111
	} tmr_wave_e;

	typedef enum logic [1:0]
	{
		KIND_PLAIN = 2'b00,
		KIND_FAST  = 2'b01,
		KIND_PHASE = 2'b10
	} tmr_kind_e;

	function automatic tmr_kind_e tmr_kind(input logic [2:0] m);
		if (m == WM_PC_FF || m == WM_PC_A)
			return KIND_PHASE;
		else if (m == WM_FP_FF || m == WM_FP_A)
			return KIND_FAST;
		else
			return KIND_PLAIN;
	endfunction

endpackage

// [tmr_top.sv]
// Module: 8-bit timer with two compare channels behind an AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
module tmr_top
	import tmr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        tick_enable,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             wave_out_a,
	output logic             wave_oe_a,
	output logic             wave_out_b,
	output logic             wave_oe_b
);
	tmr_evt_if ev ();

	logic [7:0]  ctrl_a_ff;
	logic        ws2_ff;
	logic [7:0]  count_ff;
	logic        up_ff;
	logic [2:0]  flags_ff;
	logic [3:0]  pins_ff;
	logic [31:0] hrdata_ff;
	logic        wr_ph_ff;
	logic [7:0]  wr_addr_ff;
	logic        rd_ph_ff;
	logic [7:0]  rd_addr_ff;
	logic [7:0]  nxt_count;
	logic        nxt_up;
	logic [2:0]  mode;
	logic [7:0]  top;
	logic [1:0]  out_mode_chan_a;
	logic [1:0]  out_mode_chan_b;
	logic [7:0]  match_value_a;
	logic [7:0]  match_value_b;
	logic [7:0]  buf_a;
	logic [7:0]  buf_b;
	logic        hit_a;
	logic        hit_b;
	logic        wave_a;
	logic        wave_b;
	logic        wr_a;
	logic        wr_b;
	logic        wr_cnt;
	logic        wrap_set;
	logic        a_clears;
	logic        at_top;
	logic        at_bottom;
	logic [7:0]  wdat;
	logic        acc;

	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	// ==========================================================
	// Mode decode
	assign out_mode_chan_a = ctrl_a_ff[CA_OMA_HI:CA_OMA_LO];
	assign out_mode_chan_b = ctrl_a_ff[CA_OMB_HI:CA_OMB_LO];
	assign mode      = {ws2_ff, ctrl_a_ff[CA_WSL_HI:CA_WSL_LO]};
	assign top       = (mode == WM_CTC || mode == WM_PC_A || mode == WM_FP_A)
		? match_value_a : VAL_MAX;
	assign at_top    = (count_ff == top);
	assign at_bottom = (count_ff == VAL_BOTTOM);
	assign a_clears  = (mode == WM_CTC || mode == WM_FP_A);

	assign ev.tick          = tick_enable;
	assign ev.kind          = tmr_kind(mode);
	assign ev.count_up      = up_ff;
	assign ev.at_bottom     = at_bottom;
	assign ev.at_top        = at_top;
	assign ev.count         = count_ff;
	assign ev.top           = top;
	assign ev.wave_sel_bit2 = ws2_ff;

	// ==========================================================
	// Counter
	always_comb
	begin
		nxt_count = count_ff;
		nxt_up    = up_ff;
		if (tick_enable)
		begin
			case (mode)
				WM_PC_FF, WM_PC_A:
				begin
					// TOP stands one tick only, like BOTTOM, so the period stays symmetric
					if (up_ff && at_top)
					begin
						nxt_up    = 1'b0;
						nxt_count = at_bottom ? count_ff : 8'(count_ff - 8'h01);
					end
					else if (!up_ff && at_bottom)
					begin
						nxt_up    = 1'b1;
						nxt_count = 8'h01;
					end
					else if (up_ff)
						nxt_count = 8'(count_ff + 8'h01);
					else
						nxt_count = 8'(count_ff - 8'h01);
				end
				WM_CTC, WM_FP_FF, WM_FP_A:
				begin
					nxt_up = 1'b1;
					if (at_top)
						nxt_count = VAL_BOTTOM;
					else
						nxt_count = 8'(count_ff + 8'h01);
				end
				WM_RSV4, WM_RSV6:
				begin
					nxt_count = count_ff;
				end
				default:
				begin
					nxt_up    = 1'b1;
					nxt_count = 8'(count_ff + 8'h01);
				end
			endcase
		end
		if (wr_cnt)
			nxt_count = wdat;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			count_ff <= 8'h00;
		else
			count_ff <= nxt_count;
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			up_ff <= 1'b1;
		else
			up_ff <= nxt_up;
	end

	// ==========================================================
	// Flags: set beats write-one-to-clear
	always_comb
	begin
		case (mode)
			WM_PC_FF, WM_PC_A: wrap_set = tick_enable && at_bottom && !up_ff;
			WM_FP_A:           wrap_set = tick_enable && at_top;
			WM_RSV4, WM_RSV6:  wrap_set = 1'b0;
			default:           wrap_set = tick_enable && (count_ff == VAL_MAX);
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			flags_ff <= 3'h0;
		else
		begin
			if (wrap_set)
				flags_ff[FL_WRAP] <= 1'b1;
			else if (wr_ph_ff && is_addr(wr_addr_ff, ADDR_FLAGS) && wdat[FL_WRAP])
				flags_ff[FL_WRAP] <= 1'b0;
			if (hit_a)
				flags_ff[FL_MA] <= 1'b1;
			else if (wr_ph_ff && is_addr(wr_addr_ff, ADDR_FLAGS) && wdat[FL_MA])
				flags_ff[FL_MA] <= 1'b0;
			if (hit_b)
				flags_ff[FL_MB] <= 1'b1;
			else if (wr_ph_ff && is_addr(wr_addr_ff, ADDR_FLAGS) && wdat[FL_MB])
				flags_ff[FL_MB] <= 1'b0;
		end
	end

	// ==========================================================
	// Compare channels
	tmr_wave_unit #(.CHAN_A(1'b1)) u_chan_a
	(
		.clk         (clk),
		.srst        (srst),
		.ev          (ev),
		.out_mode    (out_mode_chan_a),
		.wr_value    (wdat),
		.wr_en       (wr_a),
		.match_value (match_value_a),
		.match_buf   (buf_a),
		.match_hit   (hit_a),
		.wave_ff     (wave_a)
	);

	tmr_wave_unit #(.CHAN_A(1'b0)) u_chan_b
	(
		.clk         (clk),
		.srst        (srst),
		.ev          (ev),
		.out_mode    (out_mode_chan_b),
		.wr_value    (wdat),
		.wr_en       (wr_b),
		.match_value (match_value_b),
		.match_buf   (buf_b),
		.match_hit   (hit_b),
		.wave_ff     (wave_b)
	);

	// ==========================================================
	// Pin mux: PWM code 01 on B, or on A without bit2, stays disconnected
	always_comb
	begin
		wave_oe_a  = pins_ff[PN_DIRA];
		wave_oe_b  = pins_ff[PN_DIRB];
		wave_out_a = pins_ff[PN_DATA];
		wave_out_b = pins_ff[PN_DATB];
		if (out_mode_chan_a != OM_OFF &&
			!(ev.kind != KIND_PLAIN && out_mode_chan_a == OM_TGL && !ws2_ff))
			wave_out_a = wave_a;
		if (out_mode_chan_b != OM_OFF &&
			!(ev.kind != KIND_PLAIN && out_mode_chan_b == OM_TGL))
			wave_out_b = wave_b;
	end

	// ==========================================================
	// AHB-Lite slave, zero wait states
	assign acc       = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_ff;
	assign wdat      = hwdata[7:0];
	assign wr_a      = wr_ph_ff && is_addr(wr_addr_ff, ADDR_MATCHA);
	assign wr_b      = wr_ph_ff && is_addr(wr_addr_ff, ADDR_MATCHB);
	assign wr_cnt    = wr_ph_ff && is_addr(wr_addr_ff, ADDR_COUNT);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wr_ph_ff   <= 1'b0;
			rd_ph_ff   <= 1'b0;
			wr_addr_ff <= 8'h00;
			rd_addr_ff <= 8'h00;
		end
		else
		begin
			wr_ph_ff   <= acc && hwrite;
			rd_ph_ff   <= acc && !hwrite;
			wr_addr_ff <= haddr[7:0];
			rd_addr_ff <= haddr[7:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctrl_a_ff <= CTRL_A_RST;
			ws2_ff    <= 1'b0;
			pins_ff   <= 4'h0;
		end
		else if (wr_ph_ff)
		begin
			if (is_addr(wr_addr_ff, ADDR_CTRL_A))
				ctrl_a_ff <= wdat & CTRL_A_MSK;
			else if (is_addr(wr_addr_ff, ADDR_CTRL_B))
				ws2_ff <= wdat[CB_WS2];
			else if (is_addr(wr_addr_ff, ADDR_PINS))
				pins_ff <= wdat[3:0];
		end
	end

	// Read data registered from the address phase: one-cycle data phase
	always_ff @(posedge clk)
	begin
		if (srst)
			hrdata_ff <= 32'h0000_0000;
		else if (acc && !hwrite)
		begin
			if (is_addr(haddr[7:0], ADDR_CTRL_A))
				hrdata_ff <= {24'h000000, ctrl_a_ff & CTRL_A_MSK};
			else if (is_addr(haddr[7:0], ADDR_CTRL_B))
				hrdata_ff <= {28'h0000000, ws2_ff, 3'h0};
			else if (is_addr(haddr[7:0], ADDR_COUNT))
				hrdata_ff <= {24'h000000, count_ff};
			else if (is_addr(haddr[7:0], ADDR_MATCHA))
				hrdata_ff <= {24'h000000, buf_a};
			else if (is_addr(haddr[7:0], ADDR_MATCHB))
				hrdata_ff <= {24'h000000, buf_b};
			else if (is_addr(haddr[7:0], ADDR_FLAGS))
				hrdata_ff <= {29'h00000000, flags_ff};
			else if (is_addr(haddr[7:0], ADDR_PINS))
				hrdata_ff <= {28'h0000000, pins_ff};
			else
				hrdata_ff <= 32'h0000_0000;
		end
	end

	logic unused_ok;
	assign unused_ok = ^{hsize, rd_ph_ff, rd_addr_ff, match_value_b};
endmodule

// [tmr_top_bench.sv]
// Testbench: register-level scenarios for the timer block
`timescale 1ns/100ps
module tmr_top_bench
	import tmr_pkg::*;
;
	logic        clk, srst, tick_enable, hsel, hwrite, hready, hreadyout, hresp;
	logic        wave_out_a, wave_oe_a, wave_out_b, wave_oe_b;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  rv;
	int          failures, compares, cycles;

	assign hready = hreadyout;

	tmr_top uut (.clk(clk), .srst(srst), .tick_enable(tick_enable), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wave_out_a(wave_out_a),
		.wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b), .wave_oe_b(wave_oe_b));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ==========================================================
	// Tasks
	task automatic report_and_stop();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Address phase held until hready, then data phase until hready
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= w;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		rv = hrdata[7:0];
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic rc(input logic [7:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 8'h00);
		chk(rv, exp);
	endtask

	// One enabled cycle in eight, as with a divide-by-8 prescaler
	task automatic ticks(input int n);
		repeat (n)
		begin
			@(posedge clk);
			tick_enable <= 1'b1;
			@(posedge clk);
			tick_enable <= 1'b0;
			repeat (6) @(posedge clk);
		end
		repeat (2) @(posedge clk);
	endtask

	// Look off the edge so a register write that just landed is visible
	task automatic pins(input logic [7:0] exp);
		@(negedge clk);
		chk({6'h00, wave_out_b, wave_out_a}, exp);
	endtask

	// ==========================================================
	// Hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			report_and_stop();
		end
	end

	// ==========================================================
	// Main sequence
	initial
	begin
		failures = 0;
		compares = 0;
		cycles = 0;
		srst = 1'b1;
		tick_enable = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		repeat (5) @(posedge clk);
		srst <= 1'b0;
		rc(ADDR_CTRL_A, CTRL_A_RST);
		rc(8'h40, 8'h00);
		wr(ADDR_CTRL_A, 8'hFF);
		rc(ADDR_CTRL_A, CTRL_A_MSK);
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_COUNT, 8'hFD);
		ticks(3);
		rc(ADDR_COUNT, 8'h00);
		rc(ADDR_FLAGS, 8'h01);
		wr(ADDR_FLAGS, 8'h07);
		wr(ADDR_PINS, 8'h0F);
		pins(8'h03);
		chk({6'h00, wave_oe_b, wave_oe_a}, 8'h03);
		wr(ADDR_PINS, 8'h03);
		wr(ADDR_MATCHA, 8'h05);
		wr(ADDR_MATCHB, 8'h05);
		// Toggle, clear, set in turn so each code leaves a level other than the one before
		for (int i = 1; i < 4; i++)
		begin
			wr(ADDR_CTRL_A, {i[1:0], i[1:0], 4'h0});
			wr(ADDR_COUNT, 8'h04);
			ticks(2);
			pins((i == 2) ? 8'h00 : 8'h03);
		end
		rc(ADDR_FLAGS, 8'h06);
		wr(ADDR_FLAGS, 8'h07);
		wr(ADDR_CTRL_A, 8'h02);
		wr(ADDR_MATCHA, 8'h03);
		wr(ADDR_COUNT, 8'h00);
		ticks(4);
		rc(ADDR_COUNT, 8'h00);
		rc(ADDR_FLAGS, 8'h02);
		wr(ADDR_FLAGS, 8'h07);
		// Match values loaded in normal mode, where writes are immediate
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_MATCHA, 8'h01);
		wr(ADDR_MATCHB, 8'h01);
		wr(ADDR_CTRL_A, 8'hB3);
		wr(ADDR_COUNT, 8'hFE);
		ticks(3);
		pins(8'h01);
		ticks(1);
		pins(8'h02);
		wr(ADDR_FLAGS, 8'h07);
		wr(ADDR_MATCHA, 8'h02);
		ticks(1);
		rc(ADDR_FLAGS, 8'h00);
		rc(ADDR_MATCHA, 8'h02);
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_MATCHA, 8'hFD);
		wr(ADDR_MATCHB, 8'hFD);
		wr(ADDR_CTRL_A, 8'hE1);
		wr(ADDR_COUNT, 8'hFC);
		ticks(2);
		pins(8'h01);
		ticks(2);
		rc(ADDR_COUNT, 8'hFE);
		ticks(2);
		pins(8'h02);
		wr(ADDR_FLAGS, 8'h07);
		wr(ADDR_COUNT, 8'h01);
		ticks(2);
		rc(ADDR_FLAGS, 8'h01);
		rc(ADDR_COUNT, 8'h01);
		// Fast PWM with match A as TOP: A toggles, B equals TOP
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_MATCHA, 8'h04);
		wr(ADDR_MATCHB, 8'h04);
		wr(ADDR_CTRL_B, 8'h08);
		wr(ADDR_CTRL_A, 8'h73);
		wr(ADDR_COUNT, 8'h02);
		wr(ADDR_FLAGS, 8'h07);
		ticks(3);
		rc(ADDR_COUNT, 8'h00);
		rc(ADDR_FLAGS, 8'h07);
		pins(8'h01);
		ticks(5);
		pins(8'h00);
		rc(ADDR_CTRL_B, 8'h08);
		wr(ADDR_PINS, 8'h07);
		wr(ADDR_CTRL_B, 8'h00);
		pins(8'h01);
		report_and_stop();
	end
endmodule

// [tmr_top_chk.sv]
// Checker: port-level properties of the timer block, bound into tmr_top
`timescale 1ns/100ps
module tmr_top_chk
	import tmr_pkg::*;
(
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        tick_enable,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        wave_out_a,
	input wire logic        wave_oe_a,
	input wire logic        wave_out_b,
	input wire logic        wave_oe_b
);
	// ==========================================================
	// Bus phase tracking and register shadows
	logic       wr_ff;
	logic       rd_ff;
	logic [7:0] adr_ff;
	logic [7:0] ctl_ff;
	logic [3:0] pin_ff;
	always_ff @(posedge clk)
	begin
		wr_ff <= !srst && hsel && hready && htrans[1] && hwrite;
		rd_ff <= !srst && hsel && hready && htrans[1] && !hwrite;
		adr_ff <= haddr[7:0];
	end
	// Shadows land on the same edge as the design's registers
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ctl_ff <= CTRL_A_RST;
			pin_ff <= 4'h0;
		end
		else if (wr_ff && adr_ff == ADDR_CTRL_A)
			ctl_ff <= hwdata[7:0] & CTRL_A_MSK;
		else if (wr_ff && adr_ff == ADDR_PINS)
			pin_ff <= hwdata[3:0];
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// ==========================================================
	// Properties
	property p_okay; hreadyout && !hresp; endproperty
	a_okay: assert property (p_okay)
		else $error("bus answer not ready or not okay");
	property p_ctl_rd; rd_ff && adr_ff == ADDR_CTRL_A |-> hrdata == {24'h000000, ctl_ff}; endproperty
	a_ctl_rd: assert property (p_ctl_rd)
		else $error("control A read back differs from written value");
	property p_stand; $changed(hrdata) |-> rd_ff || $past(srst); endproperty
	a_stand: assert property (p_stand)
		else $error("read data changed without a read");
	property p_oe_a; wave_oe_a == pin_ff[PN_DIRA]; endproperty
	a_oe_a: assert property (p_oe_a)
		else $error("pin A enable does not follow direction bit");
	property p_oe_b; wave_oe_b == pin_ff[PN_DIRB]; endproperty
	a_oe_b: assert property (p_oe_b)
		else $error("pin B enable does not follow direction bit");
	property p_port_a; ctl_ff[7:6] == OM_OFF |-> wave_out_a == pin_ff[PN_DATA]; endproperty
	a_port_a: assert property (p_port_a)
		else $error("disconnected pin A does not show port data");
	property p_port_b; ctl_ff[5:4] == OM_OFF |-> wave_out_b == pin_ff[PN_DATB]; endproperty
	a_port_b: assert property (p_port_b)
		else $error("disconnected pin B does not show port data");
	property p_act_a; $changed(wave_out_a) |-> $past(tick_enable) || $past(wr_ff) || $past(srst);
	endproperty
	a_act_a: assert property (p_act_a)
		else $error("pin A moved without tick or write");
	property p_act_b; $changed(wave_out_b) |-> $past(tick_enable) || $past(wr_ff) || $past(srst);
	endproperty
	a_act_b: assert property (p_act_b)
		else $error("pin B moved without tick or write");
endmodule

bind tmr_top tmr_top_chk u_chk (.clk(clk), .srst(srst), .tick_enable(tick_enable), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.wave_out_a(wave_out_a), .wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b),
	.wave_oe_b(wave_oe_b));

// [tmr_wave_unit.sv]
// Module: one compare channel, buffered match value and waveform register
`timescale 1ns/100ps
module tmr_wave_unit
	import tmr_pkg::*;
#(
	parameter bit CHAN_A = 1'b1
)
(
	input  wire logic       clk,
	input  wire logic       srst,
	tmr_evt_if.unit         ev,
	input  wire logic [1:0] out_mode,
	input  wire logic [7:0] wr_value,
	input  wire logic       wr_en,
	output logic [7:0]      match_value,
	output logic [7:0]      match_buf,
	output logic            match_hit,
	output logic            wave_ff
);
	logic [7:0] active_ff;
	logic [7:0] buf_ff;
	logic       nxt_wave;
	logic       at_top_match;
	logic       upd;

	assign match_value = active_ff;
	assign match_buf   = buf_ff;
	assign match_hit   = ev.tick && (ev.count == active_ff);
	assign at_top_match = (active_ff == ev.top) && out_mode[1];

	// ==========================================================
	// Buffer update point per mode
	always_comb
	begin
		case (ev.kind)
			KIND_PHASE: upd = ev.tick && ev.at_top;
			KIND_FAST:  upd = ev.tick && ev.at_top;
			default:    upd = 1'b1;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			buf_ff <= 8'h00;
		else if (wr_en)
			buf_ff <= wr_value;
	end

	// Fast PWM loads on the TOP-to-BOTTOM step, so new value rules BOTTOM
	always_ff @(posedge clk)
	begin
		if (srst)
			active_ff <= 8'h00;
		else if (ev.kind == KIND_PLAIN && wr_en)
			active_ff <= wr_value;
		else if (ev.kind != KIND_PLAIN && upd)
			active_ff <= buf_ff;
	end

	// ==========================================================
	// Waveform register
	always_comb
	begin
		nxt_wave = wave_ff;
		case (ev.kind)
			KIND_PLAIN:
			begin
				if (match_hit)
				begin
					case (out_mode)
						OM_TGL:  nxt_wave = ~wave_ff;
						OM_CLR:  nxt_wave = 1'b0;
						OM_SET:  nxt_wave = 1'b1;
						default: nxt_wave = wave_ff;
					endcase
				end
			end
			KIND_FAST:
			begin
				if (out_mode == OM_TGL)
				begin
					if (CHAN_A && ev.wave_sel_bit2 && match_hit)
						nxt_wave = ~wave_ff;
				end
				else if (out_mode[1])
				begin
					if (ev.tick && ev.at_top)
						nxt_wave = (out_mode == OM_CLR);
					else if (match_hit && !at_top_match)
						nxt_wave = (out_mode == OM_SET);
				end
			end
			KIND_PHASE:
			begin
				if (out_mode == OM_TGL)
				begin
					if (CHAN_A && ev.wave_sel_bit2 && match_hit)
						nxt_wave = ~wave_ff;
				end
				else if (out_mode[1])
				begin
					if (at_top_match)
					begin
						// Level at TOP equals that of a down-counting match
						if (ev.tick && ev.at_top)
							nxt_wave = (out_mode == OM_CLR);
					end
					else if (match_hit)
						nxt_wave = (!ev.count_up) ^ (out_mode == OM_SET);
				end
			end
			default: nxt_wave = wave_ff;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			wave_ff <= 1'b0;
		else
			wave_ff <= nxt_wave;
	end
endmodule
